// ===== core/rtc_core.sv
`timescale 1ns/1ps
// Overview of operation
// - Sixteen-bit up-counter runs on, unaffected by the sleep input.
// - Ten-bit prescaler divides reference ticks before the counter.
// - Software selects one of five reference sources for the counter.
// - Counter equal to compare value raises compare flag and event.
// - Counter equal to period value raises overflow flag and event.
// - Counter clears to zero on the first increment after it reaches the period value.
// - Mask and event enable set separately for overflow and compare.
// - An unmasked pending interrupt drives wake while asleep.
module rtc_core
  import rtc_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [DATA_W-1:0] pwdata_in,
  output logic      [DATA_W-1:0] prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire rtc_refs_t         refs_in,
  input  wire logic              sleep_in,
  output rtc_evt_t               evt_out,
  output logic                   irq_out,
  output logic                   wake_out,
  output logic      [CNT_W-1:0]  cnt_out
);

  rtc_ctrl_t         ctrl_r;
  logic [PSC_W-1:0]  psc_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  per_r;
  logic [CNT_W-1:0]  cmp_r;
  logic [FLG_W-1:0]  flags_r;
  logic [FLG_W-1:0]  flags_nxt;
  logic [FLG_W-1:0]  mask_r;
  logic [FLG_W-1:0]  evten_r;
  rtc_evt_t          evt_r;
  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] rd_nxt;
  logic              pslverr_r;
  logic              rd_hit;
  logic              ref_d_r;
  logic              sel_lvl;
  logic              ref_tick;
  logic              inc;
  logic              ovf_hit;
  logic              cmp_hit;
  logic              setup;
  logic              access;
  logic              wr_acc;
  logic              wr_ctrl;
  logic              wr_psc;
  logic              wr_cnt;
  logic              wr_per;
  logic              wr_cmp;
  logic              wr_flg;
  logic              wr_mask;
  logic              wr_evten;
  logic [FLG_W-1:0]  flg_clr;
  logic [FLG_W-1:0]  hits;
  logic [STAT_W-1:0] status;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign setup    = psel_in & ~penable_in;
  assign access   = psel_in & penable_in;
  assign wr_acc   = access & pwrite_in;
  assign wr_ctrl  = wr_acc && (paddr_in == OFF_CTRL);
  assign wr_psc   = wr_acc && (paddr_in == OFF_PRESC);
  assign wr_cnt   = wr_acc && (paddr_in == OFF_CNT);
  assign wr_per   = wr_acc && (paddr_in == OFF_PER);
  assign wr_cmp   = wr_acc && (paddr_in == OFF_CMP);
  assign wr_flg   = wr_acc && (paddr_in == OFF_FLAGS);
  assign wr_mask  = wr_acc && (paddr_in == OFF_MASK);
  assign wr_evten = wr_acc && (paddr_in == OFF_EVTEN);

  // Every access completes in its first access cycle.
  assign pready_out  = access;
  assign pslverr_out = access & pslverr_r;
  assign prdata_out  = prdata_r;

  // ****************************************************************
  // Read path
  // ****************************************************************
  assign status = {sel_lvl, sleep_in, ctrl_r.run};

  always_comb begin
    rd_nxt = RD_ZERO;
    rd_hit = 1'b1;
    case (paddr_in)
      OFF_CTRL:   rd_nxt[CTRL_W-1:0] = ctrl_r;
      OFF_PRESC:  rd_nxt[PSC_W-1:0]  = psc_r;
      OFF_CNT:    rd_nxt[CNT_W-1:0]  = cnt_r;
      OFF_PER:    rd_nxt[CNT_W-1:0]  = per_r;
      OFF_CMP:    rd_nxt[CNT_W-1:0]  = cmp_r;
      OFF_FLAGS:  rd_nxt[FLG_W-1:0]  = flags_r;
      OFF_MASK:   rd_nxt[FLG_W-1:0]  = mask_r;
      OFF_EVTEN:  rd_nxt[FLG_W-1:0]  = evten_r;
      OFF_STATUS: rd_nxt[STAT_W-1:0] = status;
      default:    rd_hit = 1'b0;
    endcase
  end

  // Read data and the error answer are captured in the setup cycle.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_r  <= RD_ZERO;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= pwrite_in ? RD_ZERO : rd_nxt;
      pslverr_r <= ~rd_hit;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= rtc_ctrl_t'(pwdata_in[CTRL_W-1:0]);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      psc_r <= PSC_CLR;
    end else if (wr_psc) begin
      psc_r <= pwdata_in[PSC_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      per_r <= PER_RST;
    end else if (wr_per) begin
      per_r <= pwdata_in[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmp_r <= CMP_RST;
    end else if (wr_cmp) begin
      cmp_r <= pwdata_in[CNT_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mask_r  <= FLG_CLR;
    end else if (wr_mask) begin
      mask_r  <= pwdata_in[FLG_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      evten_r <= FLG_CLR;
    end else if (wr_evten) begin
      evten_r <= pwdata_in[FLG_W-1:0];
    end
  end

  // ****************************************************************
  // Reference selection
  // ****************************************************************
  always_comb begin
    sel_lvl = 1'b0;
    case (ctrl_r.src)
      RTC_SRC_XTAL_1K:  sel_lvl = refs_in.xtal_1k;
      RTC_SRC_XTAL_32K: sel_lvl = refs_in.xtal_32k;
      RTC_SRC_EXT:      sel_lvl = refs_in.ext_clk;
      RTC_SRC_INT_OSC:  sel_lvl = refs_in.int_osc;
      RTC_SRC_ULP_OSC:  sel_lvl = refs_in.ultra_low_power_osc;
      default:          sel_lvl = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ref_d_r <= 1'b0;
    end else begin
      ref_d_r <= sel_lvl;
    end
  end

  // One tick per rising edge of the selected reference.
  assign ref_tick = sel_lvl & ~ref_d_r;

  rtc_prescaler u_prescaler (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .run_in  (ctrl_r.run),
    .tick_in (ref_tick),
    .div_in  (psc_r),
    .inc_out (inc)
  );

  // ****************************************************************
  // Counter
  // ****************************************************************
  assign ovf_hit = inc && (cnt_r == per_r);
  assign cmp_hit = inc && (cnt_r == cmp_r);
  assign cnt_out = cnt_r;

  // The sleep input does not gate the counter at all.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= CNT_CLR;
    end else if (wr_cnt) begin
      cnt_r <= pwdata_in[CNT_W-1:0];
    end else if (ovf_hit) begin
      cnt_r <= CNT_CLR;
    end else if (inc) begin
      cnt_r <= cnt_r + CNT_ONE;
    end
  end

  // ****************************************************************
  // Flags, interrupt and events
  // ****************************************************************
  assign hits    = {cmp_hit, ovf_hit};
  assign flg_clr = wr_flg ? pwdata_in[FLG_W-1:0] : FLG_CLR;

  // A hit in the cycle of a write-one-clear keeps the flag set.
  assign flags_nxt = (flags_r & ~flg_clr) | hits;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flags_r <= FLG_CLR;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      evt_r <= '0;
    end else begin
      evt_r.ovf <= ovf_hit & evten_r[FLG_OVF];
      evt_r.cmp <= cmp_hit & evten_r[FLG_CMP];
    end
  end

  assign evt_out  = evt_r;
  assign irq_out  = |(flags_r & mask_r);
  assign wake_out = sleep_in & irq_out;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence ovf_tick_s;
    inc && !wr_cnt && (cnt_r == per_r);
  endsequence

  sequence step_tick_s;
    inc && !wr_cnt && (cnt_r != per_r);
  endsequence

  sequence sleep_ovf_s;
    sleep_in && ovf_hit && mask_r[FLG_OVF] && !wr_mask;
  endsequence

  cnt_wrap_a: assert property (
    ovf_tick_s |=> cnt_r == CNT_CLR)
    else $error("Counter did not clear at the period value.");

  cnt_step_a: assert property (
    step_tick_s |=> cnt_r == $past(cnt_r) + CNT_ONE)
    else $error("Counter did not step by one on an increment.");

  cnt_hold_a: assert property (
    (!inc && !wr_cnt) |=> $stable(cnt_r))
    else $error("Counter moved without an increment.");

  sleep_count_a: assert property (
    (sleep_in and step_tick_s) |=> cnt_r != $past(cnt_r))
    else $error("Counter stalled while asleep.");

  ovf_flag_a: assert property (
    ovf_hit |=> flags_r[FLG_OVF])
    else $error("Overflow flag missing after a period match.");

  cmp_flag_a: assert property (
    cmp_hit |=> flags_r[FLG_CMP] [*1] ##0 (irq_out || !mask_r[FLG_CMP]))
    else $error("Compare flag missing after a compare match.");

  ovf_evt_a: assert property (
    evt_out.ovf |-> $past(ovf_hit) && $past(evten_r[FLG_OVF]))
    else $error("Overflow event without an enabled match.");

  cmp_evt_a: assert property (
    (cmp_hit && !evten_r[FLG_CMP]) |=> !evt_out.cmp)
    else $error("Compare event fired while disabled.");

  src_sel_a: assert property (
    (ref_tick && ctrl_r.src == RTC_SRC_XTAL_32K) |-> refs_in.xtal_32k)
    else $error("Tick taken from an unselected reference.");

  wake_a: assert property (
    sleep_ovf_s ##1 sleep_in |-> wake_out)
    else $error("No wake on an unmasked overflow during sleep.");

  sequence ovf_evt_s;
    ovf_hit && evten_r[FLG_OVF];
  endsequence

  ovf_pulse_a: assert property (
    ovf_evt_s |=> evt_out.ovf ##1 !evt_out.ovf)
    else $error("Overflow event not a single-cycle pulse.");

  cmp_evt_on_a: assert property (
    (cmp_hit && evten_r[FLG_CMP]) |=> evt_out.cmp)
    else $error("Compare event missing while enabled.");

  flag_clear_a: assert property (
    (wr_flg && pwdata_in[FLG_OVF] && !ovf_hit) |=> !flags_r[FLG_OVF])
    else $error("Overflow flag survived a write-one clear.");

  wake_sleep_a: assert property (
    wake_out |-> sleep_in && irq_out)
    else $error("Wake raised without sleep and a pending interrupt.");

  stop_freeze_a: assert property (
    !ctrl_r.run |-> !inc)
    else $error("Increment issued while the counter is stopped.");

  irq_mask_a: assert property (
    (flags_r[FLG_CMP] && !mask_r[FLG_CMP] && !flags_r[FLG_OVF])
      |-> !irq_out)
    else $error("Masked compare flag raised the interrupt.");

  src_ulp_a: assert property (
    (ref_tick && ctrl_r.src == RTC_SRC_ULP_OSC)
      |-> refs_in.ultra_low_power_osc)
    else $error("Tick taken from an unselected reference.");

endmodule

// ===== core/rtc_pkg.sv
package rtc_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int PSC_W  = 10;
  localparam int FLG_W  = 2;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PRESC  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CNT    = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PER    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CMP    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_FLAGS  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_EVTEN  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FLG_OVF   = 0;
  localparam int FLG_CMP   = 1;
  localparam int CTRL_W    = 4;
  localparam int STAT_RUN  = 0;
  localparam int STAT_SLP  = 1;
  localparam int STAT_REF  = 2;
  localparam int STAT_W    = 3;

  // ****************************************************************
  // Reset and clear values
  // ****************************************************************
  localparam logic [CNT_W-1:0]  CNT_CLR  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0]  PER_RST  = 16'hFFFF;
  localparam logic [CNT_W-1:0]  CMP_RST  = 16'h0000;
  localparam logic [PSC_W-1:0]  PSC_CLR  = 10'h000;
  localparam logic [PSC_W-1:0]  PSC_ONE  = 10'h001;
  localparam logic [FLG_W-1:0]  FLG_CLR  = 2'h0;
  localparam logic [DATA_W-1:0] RD_ZERO  = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    RTC_SRC_XTAL_1K  = 3'b000,
    RTC_SRC_XTAL_32K = 3'b001,
    RTC_SRC_EXT      = 3'b010,
    RTC_SRC_INT_OSC  = 3'b011,
    RTC_SRC_ULP_OSC  = 3'b100
  } rtc_src_t;

  typedef struct packed {
    rtc_src_t src;
    logic     run;
  } rtc_ctrl_t;

  typedef struct packed {
    logic ultra_low_power_osc;
    logic int_osc;
    logic ext_clk;
    logic xtal_32k;
    logic xtal_1k;
  } rtc_refs_t;

  typedef struct packed {
    logic cmp;
    logic ovf;
  } rtc_evt_t;

  localparam rtc_ctrl_t CTRL_RST = '{src: RTC_SRC_XTAL_1K, run: 1'b0};

endpackage

// ===== core/rtc_prescaler.sv
`timescale 1ns/1ps
module rtc_prescaler
  import rtc_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             run_in,
  input  wire logic             tick_in,
  input  wire logic [PSC_W-1:0] div_in,
  output logic                  inc_out
);

  logic [PSC_W-1:0] cnt_r;
  logic             wrap;

  // ****************************************************************
  // Division
  // ****************************************************************
  // A ratio lowered below the running count wraps at the next tick.
  assign wrap    = cnt_r >= div_in;
  assign inc_out = run_in & tick_in & wrap;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= PSC_CLR;
    end else if (!run_in) begin
      cnt_r <= PSC_CLR;
    end else if (tick_in) begin
      if (wrap) begin
        cnt_r <= PSC_CLR;
      end else begin
        cnt_r <= cnt_r + PSC_ONE;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  inc_on_tick_a: assert property (
    inc_out |-> tick_in && run_in)
    else $error("Increment without a reference tick.");

  presc_div_a: assert property (
    (inc_out && div_in != PSC_CLR) |=> !inc_out)
    else $error("Prescaler fired twice with a ratio above one.");

  presc_ratio_a: assert property (
    (tick_in && run_in && !wrap && $stable(div_in)) |=> cnt_r != PSC_CLR)
    else $error("Prescaler count lost a reference tick.");

endmodule

// ===== verification/tb_rtc_16bit_counter.sv
`timescale 1ns/1ps
module tb_rtc_16bit_counter
  import rtc_pkg::*;
;
  logic              clk_in;
  logic              rstn_in;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [4:0]        refs_v;
  logic              sleep;
  rtc_evt_t          evt;
  logic              irq;
  logic              wake;
  logic [CNT_W-1:0]  cnt;
  int                n_fail;
  int                num_checks;
  int                n_ovf;
  int                n_cmp;

  rtc_core rtc_core_i (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .psel_in     (psel),
    .penable_in  (penable),
    .pwrite_in   (pwrite),
    .paddr_in    (paddr),
    .pwdata_in   (pwdata),
    .prdata_out  (prdata),
    .pready_out  (pready),
    .pslverr_out (pslverr),
    .refs_in     (rtc_refs_t'(refs_v)),
    .sleep_in    (sleep),
    .evt_out     (evt),
    .irq_out     (irq),
    .wake_out    (wake),
    .cnt_out     (cnt)
  );

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Each event pulse is counted per high cycle, so a wide pulse shows up.
  always @(posedge clk_in) begin
    if (evt.ovf === 1'b1) n_ovf++;
    if (evt.cmp === 1'b1) n_cmp++;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q, output logic err);
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    logic              e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] x);
    logic [DATA_W-1:0] q;
    logic              e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(nm, x, q);
  endtask

  task automatic settle();
    @(posedge clk_in);
    #1;
  endtask

  task automatic tick(input int i);
    @(posedge clk_in);
    refs_v[i] <= 1'b1;
    repeat (2) @(posedge clk_in);
    refs_v[i] <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  // **************************************************************
  // Scenarios
  // **************************************************************
  task automatic t_reset();
    logic [DATA_W-1:0] q;
    logic              e;
    rd("ctrl", OFF_CTRL, 32'h0000_0000);
    rd("per", OFF_PER, 32'h0000_FFFF);
    rd("cmp", OFF_CMP, 32'h0000_0000);
    rd("flags", OFF_FLAGS, 32'h0000_0000);
    apb(1'b1, 8'h24, 32'h0000_0001, q, e);
    chk("wr_err", 32'h0000_0001, {31'h0, e});
    apb(1'b0, 8'h24, 32'h0000_0000, q, e);
    chk("rd_err", 32'h0000_0001, {31'h0, e});
    chk("rd_unmapped", 32'h0000_0000, q);
    tick(0);
    chk("stopped_cnt", 32'h0000_0000, {16'h0, cnt});
    $display("test reset done");
  endtask

  task automatic t_sources();
    for (int s = 0; s < 5; s++) begin
      wr(OFF_CTRL, 32'((s << 1) | 1));
      wr(OFF_CNT, 32'h0000_0000);
      tick((s + 1) % 5);
      chk("other_src", 32'h0000_0000, {16'h0, cnt});
      tick(s);
      rd("src_cnt", OFF_CNT, 32'h0000_0001);
    end
    $display("test sources done");
  endtask

  task automatic t_prescale();
    wr(OFF_CTRL, 32'h0000_0001);
    wr(OFF_PRESC, 32'h0000_0002);
    wr(OFF_CNT, 32'h0000_0000);
    repeat (5) tick(0);
    chk("psc_cnt5", 32'h0000_0001, {16'h0, cnt});
    tick(0);
    chk("psc_cnt6", 32'h0000_0002, {16'h0, cnt});
    rd("presc", OFF_PRESC, 32'h0000_0002);
    wr(OFF_PRESC, 32'h0000_0000);
    $display("test prescale done");
  endtask

  task automatic t_wrap_sleep();
    int o;
    rd("flags_pre", OFF_FLAGS, 32'h0000_0002);
    wr(OFF_FLAGS, 32'h0000_0003);
    wr(OFF_PER, 32'h0000_0005);
    wr(OFF_CMP, 32'h0000_0100);
    wr(OFF_MASK, 32'h0000_0001);
    wr(OFF_EVTEN, 32'h0000_0001);
    wr(OFF_CNT, 32'h0000_0004);
    sleep <= 1'b1;
    o = n_ovf;
    tick(0);
    chk("cnt_5", 32'h0000_0005, {16'h0, cnt});
    chk("no_ovf", 32'(o), 32'(n_ovf));
    chk("no_irq", 32'h0000_0000, {31'h0, irq});
    tick(0);
    chk("wrap_cnt", 32'h0000_0000, {16'h0, cnt});
    chk("ovf_pulse", 32'(o + 1), 32'(n_ovf));
    chk("irq_ovf", 32'h0000_0001, {31'h0, irq});
    chk("wake", 32'h0000_0001, {31'h0, wake});
    rd("flags_ovf", OFF_FLAGS, 32'h0000_0001);
    rd("status", OFF_STATUS, 32'h0000_0003);
    wr(OFF_FLAGS, 32'h0000_0001);
    settle();
    chk("irq_clr", 32'h0000_0000, {31'h0, irq});
    chk("wake_clr", 32'h0000_0000, {31'h0, wake});
    repeat (6) tick(0);
    chk("second_wrap", 32'(o + 2), 32'(n_ovf));
    sleep <= 1'b0;
    wr(OFF_FLAGS, 32'h0000_0003);
    $display("test wrap_sleep done");
  endtask

  task automatic t_compare();
    int o;
    int c;
    wr(OFF_PER, 32'h0000_FFFF);
    wr(OFF_CMP, 32'h0000_0002);
    wr(OFF_MASK, 32'h0000_0000);
    wr(OFF_EVTEN, 32'h0000_0002);
    wr(OFF_CNT, 32'h0000_0002);
    o = n_ovf;
    c = n_cmp;
    tick(0);
    chk("cmp_pulse", 32'(c + 1), 32'(n_cmp));
    chk("ovf_quiet", 32'(o), 32'(n_ovf));
    chk("irq_masked", 32'h0000_0000, {31'h0, irq});
    rd("flags_cmp", OFF_FLAGS, 32'h0000_0002);
    wr(OFF_MASK, 32'h0000_0002);
    settle();
    chk("irq_cmp", 32'h0000_0001, {31'h0, irq});
    wr(OFF_EVTEN, 32'h0000_0000);
    wr(OFF_CNT, 32'h0000_0002);
    tick(0);
    chk("cmp_evt_off", 32'(c + 1), 32'(n_cmp));
    wr(OFF_FLAGS, 32'h0000_0002);
    settle();
    chk("irq_cmp_clr", 32'h0000_0000, {31'h0, irq});
    $display("test compare done");
  endtask

  initial begin
    #200000;
    n_fail++;
    $display("MISMATCH watchdog expected finish seen timeout");
    complete_run();
  end

  initial begin
    n_fail = 0;
    num_checks = 0;
    n_ovf = 0;
    n_cmp = 0;
    rstn_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    refs_v = 5'h00;
    sleep = 1'b0;
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_sources();
    t_prescale();
    t_wrap_sleep();
    t_compare();
    complete_run();
  end
endmodule
